/* design/kpi_pkg.sv */
package kpi_pkg;

   // Register offsets on the plain register port.
   localparam logic [1:0] KPI_ADDR_STATUS = 2'h0;
   localparam logic [1:0] KPI_ADDR_PIN_EN = 2'h1;
   localparam int KPI_ADDR_W = 2;
   localparam int KPI_DATA_W = 8;
   localparam int KPI_PINS = 8;

   // Field positions in the status and control register.
   localparam int KPI_BIT_MODE = 0;
   localparam int KPI_BIT_IRQ_EN = 1;
   localparam int KPI_BIT_ACK = 2;
   localparam int KPI_BIT_FLAG = 3;
   localparam int KPI_POL_LO = 4;
   localparam int KPI_POL_HI = 7;

   // Values after reset.
   localparam logic [7:0] KPI_STATUS_RST = 8'h00;
   localparam logic [7:0] KPI_PIN_EN_RST = 8'h00;

   // Polarity bits exist only for the upper four pins.
   localparam logic [3:0] KPI_LOW_POL = 4'h0;

   typedef enum logic {
      KPI_EDGE_ONLY,
      KPI_EDGE_LEVEL
   } kpi_mode_t;

   // Marks each enabled pin that sits at its asserted level.
   function automatic logic [7:0] kpi_asserted(input logic [7:0] lvl,
                                                input logic [3:0] pol,
                                                input logic [7:0] en);
      kpi_asserted = (lvl ~^ {pol, KPI_LOW_POL}) & en;
   endfunction : kpi_asserted

endpackage : kpi_pkg

/* design/kpi_det_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface kpi_det_if;
   logic [7:0] pin_en;
   logic [3:0] pol;
   logic level_mode;
   logic edge_hit;
   logic level_hit;

   modport ctrl (
      output pin_en,
      output pol,
      output level_mode,
      input edge_hit,
      input level_hit
   );

   modport det (
      input pin_en,
      input pol,
      input level_mode,
      output edge_hit,
      output level_hit
   );
endinterface : kpi_det_if

`default_nettype wire

/* design/kpi_pin_detect.sv */
`timescale 1ns/1ns
`default_nettype none

module kpi_pin_detect (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Raw key pins.
   input wire logic [7:0] key_pin_in,
   // Configuration and results.
   kpi_det_if.det det
);

   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] prev;
      logic armed;
   } kpi_det_st_t;

   kpi_det_st_t st_ff;
   kpi_det_st_t nxt_st;
   logic [7:0] cur_a;
   logic [7:0] prev_a;
   logic level_init;

   // Both samples are judged under the present polarity, so a polarity
   // change on a pin held low does not look like an edge; software need
   // not disable the pin to change polarity.
   assign cur_a = kpi_pkg::kpi_asserted(st_ff.sync2, det.pol, det.pin_en);
   assign prev_a = kpi_pkg::kpi_asserted(st_ff.prev, det.pol, det.pin_en);
   // An initial event needs every enabled pin deasserted beforehand.
   assign level_init = (prev_a == 8'h00) && (cur_a != 8'h00);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sync1 = key_pin_in;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev = st_ff.sync2;
      nxt_st.armed = det.level_mode && (level_init || st_ff.armed) && (cur_a != 8'h00);
   end

   // In edge-only mode, deasserted then asserted in consecutive samples is an edge.
   assign det.edge_hit = det.level_mode ? level_init : |(cur_a & ~prev_a);
   assign det.level_hit = det.level_mode && st_ff.armed && (cur_a != 8'h00);

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_low_pins_fixed: assert property (cur_a[3:0] == (~st_ff.sync2[3:0] & det.pin_en[3:0]))
      else $error("lower pins do not use falling polarity");
   a_rise_edge_seen: assert property (!det.level_mode && det.pin_en[7] && det.pol[3]
      && !st_ff.prev[7] && st_ff.sync2[7] |-> det.edge_hit)
      else $error("rising edge on pin 7 missed");
   a_fall_edge_seen: assert property (!det.level_mode && det.pin_en[0]
      && $fell(st_ff.sync2[0]) |-> det.edge_hit)
      else $error("falling edge on pin 0 missed");
   a_sync_two_stage: assert property ($rose(key_pin_in[0]) ##1 1 |-> ##1 st_ff.sync2[0])
      else $error("synchroniser depth is not two");

endmodule : kpi_pin_detect

`default_nettype wire

/* design/kpi_keypad_interrupt_unit.sv */
// Contract
// - Upper polarity bits pick the trigger sense of pins 7 to 4.
// - Polarity one means rising edge or high level; zero means falling or low.
// - Pins 3 to 0 detect only falling edges or low levels.
// - The event flag sets when a trigger is seen on any enabled pin.
// - Writing one to acknowledge clears the event flag.
// - The acknowledge bit is write only and reads as zero.
// - In level mode an asserted enabled pin sets the flag every cycle; here only once armed by an initial event from all enabled pins at rest.
// - With interrupts enabled, the request follows the event flag.
// - With interrupts disabled no request, yet the flag still sets.
// - Mode bit zero is edge only, one is edge and level.
// - Each pin enable bit connects its pin to the detector.
// - A falling edge is a one sample followed by a zero sample.
// - A rising edge is a zero sample followed by a one sample.
// - Level mode first sets when pins assert while all others rest.
// - In stop mode enabled pins wake asynchronously by level.
// - In edge-only mode acknowledge clears the flag unless a new edge arrives in that cycle.
// - Enabled pins are forced to behave as inputs.
// - An enabled keyboard event wakes the core from wait or stop; wait wake here follows irq_out, so it also needs the interrupt enable.
`timescale 1ns/1ns
`default_nettype none

module kpi_keypad_interrupt_unit (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Register port.
   input wire logic [1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Key pins and port control.
   input wire logic [7:0] key_pin_in,
   output logic [7:0] pin_force_input_out,
   // Core interface.
   input wire logic wait_mode_in,
   input wire logic stop_mode_in,
   output logic irq_out,
   output logic wake_out
);

   typedef struct packed {
      logic [3:0] pol;
      logic flag;
      logic irq_en;
      kpi_pkg::kpi_mode_t mode;
      logic [7:0] pin_en;
      logic [7:0] rdata;
   } kpi_ctl_t;

   localparam kpi_ctl_t KPI_CTL_RST = '{
      pol: kpi_pkg::KPI_STATUS_RST[kpi_pkg::KPI_POL_HI:kpi_pkg::KPI_POL_LO],
      flag: kpi_pkg::KPI_STATUS_RST[kpi_pkg::KPI_BIT_FLAG],
      irq_en: kpi_pkg::KPI_STATUS_RST[kpi_pkg::KPI_BIT_IRQ_EN],
      mode: kpi_pkg::KPI_EDGE_ONLY,
      pin_en: kpi_pkg::KPI_PIN_EN_RST,
      rdata: 8'h00
   };

   kpi_det_if det_bus ();

   kpi_ctl_t st_ff;
   kpi_ctl_t nxt_st;
   logic wr_status;
   logic wr_pin_en;
   logic ack_write;
   logic flag_set;
   logic [7:0] status_view;
   logic [7:0] raw_asserted;

   // Address decode shared by the write and read paths.
   function automatic logic reg_hit(input logic [1:0] addr,
                                    input logic [1:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   assign wr_status = reg_wr_in && reg_hit(reg_addr_in, kpi_pkg::KPI_ADDR_STATUS);
   assign wr_pin_en = reg_wr_in && reg_hit(reg_addr_in, kpi_pkg::KPI_ADDR_PIN_EN);
   assign ack_write = wr_status && reg_wdata_in[kpi_pkg::KPI_BIT_ACK];

   // Configuration handed to the pin detector.
   assign det_bus.pin_en = st_ff.pin_en;
   assign det_bus.pol = st_ff.pol;
   assign det_bus.level_mode = (st_ff.mode == kpi_pkg::KPI_EDGE_LEVEL);

   kpi_pin_detect u_detect (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .key_pin_in(key_pin_in),
      .det(det_bus.det)
   );

   // Any detected event, or a held level in level mode, raises the flag.
   assign flag_set = det_bus.edge_hit || det_bus.level_hit;

   // The acknowledge bit always reads as zero.
   assign status_view = {
      st_ff.pol,
      st_ff.flag,
      1'b0,
      st_ff.irq_en,
      st_ff.mode
   };

   always_comb
   begin
      nxt_st = st_ff;
      if (wr_status)
      begin
         nxt_st.pol = reg_wdata_in[kpi_pkg::KPI_POL_HI:kpi_pkg::KPI_POL_LO];
         nxt_st.irq_en = reg_wdata_in[kpi_pkg::KPI_BIT_IRQ_EN];
         nxt_st.mode = kpi_pkg::kpi_mode_t'(reg_wdata_in[kpi_pkg::KPI_BIT_MODE]);
      end
      if (wr_pin_en)
      begin
         nxt_st.pin_en = reg_wdata_in;
      end
      // A new event in the acknowledge cycle wins over the clear, which also
      // keeps the flag stuck while a level is held in level mode.
      nxt_st.flag = (st_ff.flag && !ack_write) || flag_set;
      // Read data stand for one cycle only and are zero otherwise.
      nxt_st.rdata = 8'h00;
      if (reg_rd_in)
      begin
         if (reg_hit(reg_addr_in, kpi_pkg::KPI_ADDR_STATUS))
         begin
            nxt_st.rdata = status_view;
         end
         else if (reg_hit(reg_addr_in, kpi_pkg::KPI_ADDR_PIN_EN))
         begin
            nxt_st.rdata = st_ff.pin_en;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         st_ff <= KPI_CTL_RST;
      else
         st_ff <= nxt_st;
   end

   assign reg_rdata_out = st_ff.rdata;

   // Enabled pins override the port direction so they are never driven.
   assign pin_force_input_out = st_ff.pin_en;

   // The request is gated by the enable; polling works either way.
   assign irq_out = st_ff.flag && st_ff.irq_en;

   // With clocks halted the synchronisers cannot run, so stop mode looks at
   // the raw pins directly; this path is level sensitive and glitch prone by
   // nature and must only be used while the core is stopped.
   assign raw_asserted = kpi_pkg::kpi_asserted(key_pin_in, st_ff.pol, st_ff.pin_en);

   // Wait mode wakes on the interrupt request, stop mode on a raw level.
   assign wake_out = (wait_mode_in && irq_out)
      || (stop_mode_in && (raw_asserted != 8'h00));

   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_edge_sets_flag: assert property (det_bus.edge_hit |=> st_ff.flag)
      else $error("detected event did not set the flag");

   a_ack_clears_edge: assert property (ack_write && !flag_set
      && st_ff.mode == kpi_pkg::KPI_EDGE_ONLY |=> !st_ff.flag)
      else $error("acknowledge did not clear the flag in edge mode");

   a_ack_clears_flag: assert property (st_ff.flag && ack_write && !flag_set
      ##1 !flag_set |-> ##1 !st_ff.flag)
      else $error("flag came back without a new event");

   a_level_holds_flag: assert property (det_bus.level_hit && ack_write
      |=> st_ff.flag)
      else $error("held level let the flag clear");

   a_ack_reads_zero: assert property (reg_rd_in |=> reg_rdata_out[kpi_pkg::KPI_BIT_ACK] == 1'b0)
      else $error("acknowledge bit read back as one");

   a_irq_enabled: assert property (st_ff.flag && st_ff.irq_en |-> irq_out
      ##1 (irq_out || !st_ff.flag))
      else $error("interrupt request missing while flag set");

   a_irq_masked: assert property (!st_ff.irq_en |-> !irq_out)
      else $error("interrupt requested while disabled");

   a_poll_masked: assert property (!st_ff.irq_en && flag_set |=> st_ff.flag && !irq_out)
      else $error("flag did not set for polling");

   a_mode_write: assert property (wr_status ##1 reg_rd_in
      && reg_hit(reg_addr_in, kpi_pkg::KPI_ADDR_STATUS)
      |=> reg_rdata_out[kpi_pkg::KPI_BIT_MODE] == $past(reg_wdata_in[kpi_pkg::KPI_BIT_MODE], 2))
      else $error("mode bit did not read back as written");

   a_no_spurious_flag: assert property (!st_ff.flag && !flag_set |=> !st_ff.flag)
      else $error("flag set with no event");

   a_force_input: assert property (wr_pin_en |=> pin_force_input_out == $past(reg_wdata_in))
      else $error("enabled pin not forced to input");

   a_stop_wake: assert property (stop_mode_in && (raw_asserted != 8'h00) |-> wake_out)
      else $error("no wake on asserted level in stop");

   a_wait_wake: assert property (wait_mode_in && irq_out |-> wake_out)
      else $error("no wake on request in wait");

   a_read_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data stood beyond one cycle");

   c_edge_event: cover property (!st_ff.flag ##1 st_ff.flag && !det_bus.level_mode);
   c_level_hold: cover property (det_bus.level_hit && ack_write ##1 st_ff.flag);
   c_ack_clear: cover property (st_ff.flag && ack_write ##1 !st_ff.flag);
   c_irq_raised: cover property (!irq_out ##1 irq_out);

endmodule : kpi_keypad_interrupt_unit

`default_nettype wire

/* testbench/kpi_key_model.sv */
`timescale 1ns/1ns
`default_nettype none

module kpi_key_model (
   // Rest level of each key and which keys are held.
   input wire logic [7:0] rest_lvl_in,
   input wire logic [7:0] press_in,
   // Pin levels seen by the unit.
   output logic [7:0] key_pin_out
);
   // A held key drives the inverse of its rest level; bounce is not modelled.
   assign key_pin_out = rest_lvl_in ^ press_in;
endmodule : kpi_key_model

`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic clk_in, sys_rst_in, reg_wr, reg_rd, wait_mode, stop_mode, irq, wake;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, rdata, key_pin, force_in, rest, press, lfsr, d, p;
   int bad_count, compares, ie, al;

   kpi_keypad_interrupt_unit dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .key_pin_in(key_pin),
      .pin_force_input_out(force_in), .wait_mode_in(wait_mode),
      .stop_mode_in(stop_mode), .irq_out(irq), .wake_out(wake));
   kpi_key_model km_u (.rest_lvl_in(rest), .press_in(press), .key_pin_out(key_pin));

   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // The extra edge keeps back-to-back calls from driving a strobe twice at once.
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      @(posedge clk_in);
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1 v = rdata;
      @(posedge clk_in);
   endtask : rd

   task automatic end_of_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      end_of_test();
   end

   initial
   begin
      {reg_wr, reg_rd, wait_mode, stop_mode, reg_addr, reg_wdata} = '0;
      rest = 8'hff;
      press = 8'h00;
      lfsr = 8'h09;
      sys_rst_in = 1'b1;
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      rd(2'h0, d);
      chk(d, 8'h00);
      rd(2'h1, d);
      chk(d, 8'h00);
      lfsr = lfsr_next(lfsr);
      wr(2'h1, lfsr);
      rd(2'h1, d);
      chk(d, lfsr);
      chk(force_in, lfsr);
      wr(2'h2, 8'hff);
      rd(2'h2, d);
      chk(d, 8'h00);
      // A write straight followed by a read, with no idle cycle between strobes.
      reg_addr <= 2'h0;
      reg_wdata <= 8'h03;
      reg_wr <= 1'b1;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1 d = rdata;
      chk(d, 8'h03);
      @(posedge clk_in);
      $display("register test done");
      // Each pin in turn, edge-only mode, random polarity and rest levels.
      for (int i = 0; i < 8; i++)
      begin
         lfsr = lfsr_next(lfsr);
         p = {lfsr[3:0], 4'h0};
         ie = i % 2;
         al = (i >= 4) ? p[i] : 0;
         wr(2'h1, 8'h00);
         rest <= (lfsr & ~(8'h01 << i)) | ({7'h0, ~al[0]} << i);
         wait_mode <= ie[0];
         wr(2'h0, p | 8'h04 | (ie[0] << 1));
         wr(2'h1, 8'h01 << i);
         wr(2'h0, p | 8'h04 | (ie[0] << 1));
         press[i] <= 1'b1;
         repeat (6) @(posedge clk_in);
         rd(2'h0, d);
         chk(d, p | 8'h08 | (ie[0] << 1));
         chk({7'h0, irq}, {7'h0, ie[0]});
         chk({7'h0, wake}, {7'h0, ie[0]});
         wr(2'h0, p | 8'h04 | (ie[0] << 1));
         rd(2'h0, d);
         chk(d, p | (ie[0] << 1));
         chk({7'h0, irq}, 8'h00);
         press[i] <= 1'b0;
         repeat (6) @(posedge clk_in);
      end
      wait_mode <= 1'b0;
      $display("edge test done");
      // Level mode, low polarity, pins 0 and 1 enabled, pin 2 disabled.
      wr(2'h1, 8'h00);
      rest <= 8'hff;
      wr(2'h0, 8'h05);
      wr(2'h1, 8'h03);
      wr(2'h0, 8'h05);
      press[2] <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(2'h0, d);
      chk(d, 8'h01);
      press[0] <= 1'b1;
      repeat (6) @(posedge clk_in);
      wr(2'h0, 8'h05);
      rd(2'h0, d);
      chk(d, 8'h09);
      press[1] <= 1'b1;
      press[0] <= 1'b0;
      stop_mode <= 1'b1;
      repeat (6) @(posedge clk_in);
      wr(2'h0, 8'h05);
      rd(2'h0, d);
      chk(d, 8'h09);
      chk({7'h0, wake}, 8'h01);
      press <= 8'h04;
      #1;
      chk({7'h0, wake}, 8'h00);
      repeat (6) @(posedge clk_in);
      stop_mode <= 1'b0;
      wr(2'h0, 8'h05);
      rd(2'h0, d);
      chk(d, 8'h01);
      $display("level test done");
      end_of_test();
   end
endmodule : tb

`default_nettype wire
